//--- dcc_clk_sel.sv
`include "dcc_defines.svh"
`default_nettype none
module dcc_clk_sel
    import dcc_pkg::*;
#(
    parameter int PRESC_W = `DCC_PRESC_W,
    parameter int INT_DIV = `DCC_INT_DIV
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic [2:0] cksel,
    input  wire logic       int_osc_tick,
    output var  logic       conv_tick
);
    localparam int IW = (INT_DIV > 2) ? $clog2(INT_DIV) : 1;

    if (PRESC_W < 7 || INT_DIV < 2) begin : g_chk
        $error("dcc_clk_sel: prescaler too narrow or divider below 2");
    end

    logic [PRESC_W-1:0] presc_r;
    logic [IW-1:0]      int_cnt_r;

    // low k bits all ones marks every 2^k-th system cycle
    function automatic logic presc_hit(input logic [2:0] sel,
                                       input logic [PRESC_W-1:0] cnt);
        logic [PRESC_W-1:0] mask;
        mask = PRESC_W'((1 << sel) - 1);
        return &(cnt | ~mask);
    endfunction : presc_hit

    wire logic int_hit = int_osc_tick &&
                         (int_cnt_r == IW'(INT_DIV - 1));
    wire logic sel_hit = (cksel == 3'h0) ? int_hit
                                         : presc_hit(cksel, presc_r);

    // prescaler runs on the raw clock, blind to cpu clock dividers
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            presc_r   <= '0;
            int_cnt_r <= '0;
            conv_tick <= 1'b0;
        end else begin
            presc_r   <= presc_r + 1'b1;
            if (int_osc_tick) begin
                int_cnt_r <= int_hit ? '0 : int_cnt_r + 1'b1;
            end
            conv_tick <= sel_hit;
        end
    end

    a_div2_rate: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (cksel == 3'h1 && $past(cksel) == 3'h1 && presc_r[0])
        |=> conv_tick)
        else $error("divide-by-2 converter tick missing");
    a_int_source: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (conv_tick && $past(cksel) == 3'h0) |-> $past(int_osc_tick))
        else $error("internal converter tick without oscillator edge");
endmodule : dcc_clk_sel
`default_nettype wire

//--- dcc_conv_seq.sv
`include "dcc_defines.svh"
`default_nettype none
module dcc_conv_seq
    import dcc_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic enable,
    input  wire logic dac_mode,
    input  wire logic start,
    input  wire logic conv_tick,
    output logic      busy,
    output logic      done,
    output logic      sample
);
    dcc_seq_t   state_r;
    logic [3:0] cnt_r;
    logic       mode_r;

    wire logic [3:0] last = mode_r ? 4'(`DCC_DAC_CYC - 1)
                                   : 4'(`DCC_ADC_CYC - 1);
    wire logic       fin  = conv_tick && (cnt_r == last);

    assign busy = (state_r == DCC_RUN);

    // a cleared enable aborts without raising done
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_r <= DCC_IDLE;
            cnt_r   <= 4'h0;
            mode_r  <= 1'b0;
            done    <= 1'b0;
            sample  <= 1'b0;
        end else begin
            done   <= 1'b0;
            sample <= 1'b0;
            unique case (state_r)
                DCC_IDLE: begin
                    if (start && enable) begin
                        state_r <= DCC_RUN;
                        cnt_r   <= 4'h0;
                        mode_r  <= dac_mode;
                    end
                end
                DCC_RUN: begin
                    if (!enable) begin
                        state_r <= DCC_IDLE;
                    end else if (fin) begin
                        state_r <= DCC_IDLE;
                        done    <= 1'b1;
                    end else if (conv_tick) begin
                        cnt_r  <= cnt_r + 4'h1;
                        sample <= !mode_r &&
                                  (cnt_r == 4'(`DCC_SAMPLE_CYC - 1));
                    end
                end
            endcase
        end
    end

    a_done_count: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        done |-> $past(cnt_r) == ($past(mode_r) ? 4'hA : 4'hC))
        else $error("conversion ended at wrong converter cycle");
    a_done_idle: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        done |-> !busy && $past(busy))
        else $error("busy still set after completion");
endmodule : dcc_conv_seq
`default_nettype wire

//--- dcc_defines.svh
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH
// register map of the converter block
`define DCC_CTRL_ADDR     8'hA4
`define DCC_INCTL_ADDR    8'hA5
`define DCC_CTRL_RST      8'h00
`define DCC_INCTL_RST     8'h00
`define DCC_UNMAPPED_VAL  8'h00
// control register fields
`define DCC_B_DONE        7
`define DCC_B_BUSY        6
`define DCC_B_DAC         5
`define DCC_B_EN          4
`define DCC_B_LEFT_JUSTIFY        3
`define DCC_CKSEL_MSB     2
`define DCC_CKSEL_LSB     0
// input control register trigger field
`define DCC_TRG_MSB       5
`define DCC_TRG_LSB       4
// conversion lengths in converter clocks
`define DCC_ADC_CYC       13
`define DCC_DAC_CYC       11
`define DCC_SAMPLE_CYC    2
// clock rates, converter clock generation and completion delay
`define DCC_SYS_HZ        250000000
`define DCC_INT_OSC_HZ    8000000
`define DCC_CONV_INT_HZ   2000000
`define DCC_INT_DIV       (`DCC_INT_OSC_HZ / `DCC_CONV_INT_HZ)
`define DCC_PRESC_W       7
`define DCC_DONE_DLY      2
`endif

//--- dcc_pkg.sv
`default_nettype none
package dcc_pkg;
    // conversion start source
    typedef enum logic [1:0] {
        DCC_TRG_SW   = 2'h0,
        DCC_TRG_TMR0 = 2'h1,
        DCC_TRG_TMR1 = 2'h2,
        DCC_TRG_TMR2 = 2'h3
    } dcc_trg_t;
    // sequencer state
    typedef enum logic {
        DCC_IDLE = 1'b0,
        DCC_RUN  = 1'b1
    } dcc_seq_t;
endpackage : dcc_pkg
`default_nettype wire

//--- dcc_top.sv
// Added by the designer: the strobed register port.
`include "dcc_defines.svh"
`default_nettype none
module dcc_top
    import dcc_pkg::*;
#(
    parameter int RES_W = 10
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       int_osc_tick,
    input  wire logic [2:0] tmr_ovf,
    input  wire logic       isr_ack,
    input  wire logic [9:0] adc_result,
    output logic            int_osc_en,
    output logic            conv_tick,
    output logic            conv_on,
    output logic            dac_mode,
    output logic            conv_busy,
    output logic            sample_pulse,
    output logic            dac_load,
    output logic            conv_done_flag,
    output logic      [7:0] res_hi,
    output logic      [7:0] res_lo,
    output logic      [7:0] input_control
);
    if (RES_W != 10) begin : g_chk
        $error("dcc_top: result formatter serves 10-bit results only");
    end

    // register address match, shared by read and write decode
    function automatic logic addr_is(input logic [7:0] a,
                                     input logic [7:0] base);
        return a == base;
    endfunction : addr_is

    // timer overflow picked by the trigger field
    function automatic logic tmr_pick(input dcc_trg_t t,
                                      input logic [2:0] ovf);
        logic r;
        r = 1'b0;
        unique case (t)
            DCC_TRG_SW:   r = 1'b0;
            DCC_TRG_TMR0: r = ovf[0];
            DCC_TRG_TMR1: r = ovf[1];
            DCC_TRG_TMR2: r = ovf[2];
        endcase
        return r;
    endfunction : tmr_pick

    // control register fields, input control, done delay and sequencer status
    logic       done_flag_r;
    logic       dac_r;
    logic       en_r;
    logic       left_justify_r;
    logic [2:0] cksel_r;
    logic [7:0] inctl_r;
    logic [`DCC_DONE_DLY-1:0] done_dly_r;
    logic       seq_busy;
    logic       seq_done;
    logic       seq_sample;

    // address decode
    wire logic wr_ctrl  = reg_wr && addr_is(reg_addr, `DCC_CTRL_ADDR);
    wire logic wr_inctl = reg_wr && addr_is(reg_addr, `DCC_INCTL_ADDR);
    wire logic rd_ctrl  = reg_rd && addr_is(reg_addr, `DCC_CTRL_ADDR);
    wire logic rd_inctl = reg_rd && addr_is(reg_addr, `DCC_INCTL_ADDR);

    // enable and mode as they stand after the current write, trigger field as stored
    wire logic en_nxt  = wr_ctrl ? reg_wdata[`DCC_B_EN]  : en_r;
    wire logic dac_nxt = wr_ctrl ? reg_wdata[`DCC_B_DAC] : dac_r;
    wire dcc_trg_t trigger_select = dcc_trg_t'(inctl_r[`DCC_TRG_MSB:`DCC_TRG_LSB]);

    // software start only counts in software-trigger mode
    wire logic sw_start = wr_ctrl && reg_wdata[`DCC_B_BUSY] &&
                          reg_wdata[`DCC_B_EN] &&
                          (trigger_select == DCC_TRG_SW);
    wire logic hw_start = en_r && tmr_pick(trigger_select, tmr_ovf);
    wire logic start    = sw_start || hw_start;

    // read image of the control register
    wire logic [7:0] ctrl_img = {done_flag_r, seq_busy, dac_r, en_r,
                                 left_justify_r, cksel_r};
    wire logic [7:0] rd_val   = rd_ctrl  ? ctrl_img :
                                rd_inctl ? inctl_r  : `DCC_UNMAPPED_VAL;

    // result formatting, right with sign extension or left with zeros
    wire logic [7:0] fmt_hi = left_justify_r ? adc_result[9:2]
                                     : {{6{adc_result[9]}},
                                        adc_result[9:8]};
    wire logic [7:0] fmt_lo = left_justify_r ? {adc_result[1:0], 6'h00}
                                     : adc_result[7:0];

    // converter clock: enable pulse from the selected source
    dcc_clk_sel #(
        .PRESC_W      (`DCC_PRESC_W),
        .INT_DIV      (`DCC_INT_DIV)
    ) u_clk_sel (
        .clk_sys      (clk_sys),
        .rst_b        (rst_b),
        .cksel        (cksel_r),
        .int_osc_tick (int_osc_tick),
        .conv_tick    (conv_tick)
    );

    // conversion length and busy tracking
    dcc_conv_seq u_seq (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .enable    (en_nxt),
        .dac_mode  (dac_nxt),
        .start     (start),
        .conv_tick (conv_tick),
        .busy      (seq_busy),
        .done      (seq_done),
        .sample    (seq_sample)
    );

    // oscillator stays on whatever clocks the cpu; costs some power
    assign int_osc_en     = 1'b1;
    assign conv_on        = en_r;
    assign dac_mode       = dac_r;
    assign conv_busy      = seq_busy;
    assign sample_pulse   = seq_sample;
    assign conv_done_flag = done_flag_r;
    assign input_control  = inctl_r;

    // dac data is taken into its buffer on the start cycle
    assign dac_load = start && en_nxt && dac_nxt && !seq_busy;

    // control register writes; busy and done bits are hardware-owned
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            dac_r   <= 1'b0;
            en_r    <= 1'b0;
            left_justify_r  <= 1'b0;
            cksel_r <= 3'h0;
            inctl_r <= `DCC_INCTL_RST;
        end else begin
            if (wr_ctrl) begin
                dac_r   <= reg_wdata[`DCC_B_DAC];
                en_r    <= reg_wdata[`DCC_B_EN];
                left_justify_r  <= reg_wdata[`DCC_B_LEFT_JUSTIFY];
                cksel_r <= reg_wdata[`DCC_CKSEL_MSB:`DCC_CKSEL_LSB];
            end
            if (wr_inctl) begin
                inctl_r <= reg_wdata;
            end
        end
    end

    // completion passes through system stages before it is seen
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            done_dly_r <= '0;
        end else begin
            done_dly_r <= {done_dly_r[`DCC_DONE_DLY-2:0],
                           seq_done};
        end
    end

    // an event in the clearing cycle wins over the vector clear
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            done_flag_r <= 1'b0;
        end else begin
            done_flag_r <= done_dly_r[`DCC_DONE_DLY-1] ||
                           (done_flag_r && !isr_ack);
        end
    end

    // adc result is written at completion, dac leaves it alone
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            res_hi <= 8'h00;
            res_lo <= 8'h00;
        end else if (seq_done && !dac_r) begin
            res_hi <= fmt_hi;
            res_lo <= fmt_lo;
        end
    end

    // read data stand in the cycle after the strobe only
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            reg_rdata <= `DCC_CTRL_RST;
        end else begin
            reg_rdata <= reg_rd ? rd_val : 8'h00;
        end
    end

    a_sw_launch: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (sw_start && !seq_busy) |=> conv_busy)
        else $error("software start did not raise busy");

    a_hw_launch: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (hw_start && !seq_busy && !wr_ctrl) |=> conv_busy)
        else $error("timer overflow did not start a conversion");

    a_trg_map: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (en_r && trigger_select == DCC_TRG_TMR1 && tmr_ovf == 3'h1 && !wr_ctrl
         && !seq_busy) |=> !conv_busy)
        else $error("wrong timer started a conversion");

    a_flag_delay: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        seq_done |-> ##2 done_dly_r[1] ##1 conv_done_flag)
        else $error("done flag not raised three cycles after end");

    a_flag_clear: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (isr_ack && !done_dly_r[1]) |=> !conv_done_flag)
        else $error("done flag survived the vector clear");

    a_flag_hold: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (conv_done_flag && !isr_ack) |=> conv_done_flag)
        else $error("done flag dropped without vectoring");

    a_ctrl_read: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        rd_ctrl |=> reg_rdata == $past(ctrl_img))
        else $error("control read data wrong");

    a_mode_bit: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        wr_ctrl |=> dac_mode == $past(reg_wdata[5]))
        else $error("mode bit not taken from write");

    a_enable_off: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (wr_ctrl && !reg_wdata[4]) |=> !conv_on && !conv_busy)
        else $error("converter still running after disable");

    a_left_just: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (seq_done && !dac_r && left_justify_r) |=>
        res_hi == $past(adc_result[9:2]) && res_lo[5:0] == 6'h00)
        else $error("left justified result wrong");

    a_right_just: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        (seq_done && !dac_r && !left_justify_r) |=>
        res_hi == {{6{$past(adc_result[9])}}, $past(adc_result[9:8])})
        else $error("right justified result not sign extended");

    a_osc_on: assert property (@(posedge clk_sys)
        disable iff (!rst_b)
        int_osc_en)
        else $error("internal oscillator switched off");
endmodule : dcc_top
`default_nettype wire

//--- dcc_top_tb.sv
`include "dcc_defines.svh"
`default_nettype none
module dcc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;

    // internal oscillator period in system clocks, close to 8 MHz at 250 MHz
    localparam int OSC_PER = 31;

    logic       clk_sys      = 1'b0;
    logic       rst_b        = 1'b0;
    logic [7:0] reg_addr     = 8'h00;
    logic [7:0] reg_wdata    = 8'h00;
    logic       reg_wr       = 1'b0;
    logic       reg_rd       = 1'b0;
    logic [7:0] reg_rdata;
    logic       int_osc_tick = 1'b0;
    logic [2:0] tmr_ovf      = 3'h0;
    logic       isr_ack      = 1'b0;
    logic [9:0] adc_result   = 10'h301;
    logic       int_osc_en;
    logic       conv_tick;
    logic       conv_on;
    logic       dac_mode;
    logic       conv_busy;
    logic       sample_pulse;
    logic       dac_load;
    int         n_load       = 0;
    logic       conv_done_flag;
    logic [7:0] res_hi;
    logic [7:0] res_lo;
    logic [7:0] input_control;
    int         osc_cnt      = 0;
    int         n_fail       = 0;
    int         n_compared   = 0;
    int         g;
    int         t;

    dcc_top dut_u (
        .clk_sys        (clk_sys),
        .rst_b          (rst_b),
        .reg_addr       (reg_addr),
        .reg_wdata      (reg_wdata),
        .reg_wr         (reg_wr),
        .reg_rd         (reg_rd),
        .reg_rdata      (reg_rdata),
        .int_osc_tick   (int_osc_tick),
        .tmr_ovf        (tmr_ovf),
        .isr_ack        (isr_ack),
        .adc_result     (adc_result),
        .int_osc_en     (int_osc_en),
        .conv_tick      (conv_tick),
        .conv_on        (conv_on),
        .dac_mode       (dac_mode),
        .conv_busy      (conv_busy),
        .sample_pulse   (sample_pulse),
        .dac_load       (dac_load),
        .conv_done_flag (conv_done_flag),
        .res_hi         (res_hi),
        .res_lo         (res_lo),
        .input_control  (input_control)
    );

    always #2 clk_sys = ~clk_sys;

    // dac buffer loads, counted as the design samples them
    always @(posedge clk_sys) begin
        if (dac_load === 1'b1) n_load <= n_load + 1;
    end

    // oscillator ticks keep running whatever the clock select holds
    always @(posedge clk_sys) begin
        osc_cnt      <= (osc_cnt == OSC_PER - 1) ? 0 : osc_cnt + 1;
        int_osc_tick <= (osc_cnt == OSC_PER - 1);
    end

    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // every task ends just after an edge so the caller samples settled values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        #1;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        chk("register read", exp, reg_rdata);
    endtask : rd_chk

    // gap in system clocks from the current or next tick to the one after
    task automatic tick_gap(output int gap);
        int i;
        for (i = 0; i < 1000 && conv_tick !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        for (gap = 1; gap < 1000; gap++) begin
            @(posedge clk_sys);
            #1;
            if (conv_tick === 1'b1) break;
        end
    endtask : tick_gap

    task automatic pulse_tmr(input logic [2:0] bits, input logic exp_busy);
        @(posedge clk_sys);
        tmr_ovf <= bits;
        @(posedge clk_sys);
        tmr_ovf <= 3'h0;
        #1;
        chk("busy after overflow", {7'h0, exp_busy}, {7'h0, conv_busy});
    endtask : pulse_tmr

    // counts converter ticks while busy; rt is an overflow fired mid-run
    task automatic run_conv(input int exp_ticks, input logic [2:0] rt);
        int i;
        int n;
        int ns;
        n = 0;
        ns = 0;
        for (i = 0; i < 4000; i++) begin
            if (conv_busy !== 1'b1) break;
            if (conv_tick === 1'b1) n++;
            if (sample_pulse === 1'b1) ns++;
            @(posedge clk_sys);
            tmr_ovf <= (i == 8) ? rt : 3'h0;
            #1;
        end
        if (exp_ticks >= 0) begin
            chk("ticks per conversion", 8'(exp_ticks), 8'(n));
        end
        // one sample point per adc conversion, none in dac mode
        chk("sample pulses", (exp_ticks == `DCC_DAC_CYC) ? 8'h00 : 8'h01,
            8'(ns));
        for (i = 0; i < 8 && conv_done_flag !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        chk("done flag set", 8'h01, {7'h0, conv_done_flag});
    endtask : run_conv

    task automatic ack();
        @(posedge clk_sys);
        isr_ack <= 1'b1;
        @(posedge clk_sys);
        isr_ack <= 1'b0;
        #1;
        chk("done flag cleared", 8'h00, {7'h0, conv_done_flag});
    endtask : ack

    // watchdog: the whole sequence needs well under 10000 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        $display("watchdog expired");
        wrap_up();
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        #1;
        chk("osc enable", 8'h01, {7'h0, int_osc_en});
        rd_chk(`DCC_CTRL_ADDR, `DCC_CTRL_RST);
        rd_chk(`DCC_INCTL_ADDR, `DCC_INCTL_RST);
        rd_chk(8'h10, 8'h00);
        // flag and start bits are not stored; no start without enable
        wr(`DCC_CTRL_ADDR, 8'hCD);
        chk("busy without enable", 8'h00, {7'h0, conv_busy});
        rd_chk(`DCC_CTRL_ADDR, 8'h0D);
        wr(8'h10, 8'hFF);
        rd_chk(8'h10, 8'h00);
        $display("test register map done");

        // second gap measured, the first one may be cut by the switch
        for (int k = 0; k < 8; k++) begin
            wr(`DCC_CTRL_ADDR, 8'h10 | 8'(k));
            tick_gap(g);
            tick_gap(g);
            // code zero is the default rate, a quarter of the oscillator, close to 2 MHz
            chk("tick gap", (k == 0) ? 8'(`DCC_INT_DIV * OSC_PER)
                                     : 8'(1 << k), 8'(g));
        end
        chk("enable level", 8'h01, {7'h0, conv_on});
        chk("enable alone idle", 8'h00, {7'h0, conv_busy});
        $display("test clock select done");

        wr(`DCC_CTRL_ADDR, 8'h11);
        wr(`DCC_CTRL_ADDR, 8'h51);
        chk("sw start busy", 8'h01, {7'h0, conv_busy});
        chk("adc mode", 8'h00, {7'h0, dac_mode});
        run_conv(`DCC_ADC_CYC, 3'h0);
        chk("right hi", 8'hFF, res_hi);
        chk("right lo", 8'h01, res_lo);
        rd_chk(`DCC_CTRL_ADDR, 8'h91);
        ack();
        wr(`DCC_CTRL_ADDR, 8'h59);
        run_conv(`DCC_ADC_CYC, 3'h0);
        chk("left hi", 8'hC0, res_hi);
        chk("left lo", 8'h40, res_lo);
        ack();
        wr(`DCC_CTRL_ADDR, 8'h51);
        rd_chk(`DCC_CTRL_ADDR, 8'h51);
        run_conv(-1, 3'h0);
        ack();
        $display("test adc conversion done");

        // dac runs at half the system clock, below the cpu clock
        wr(`DCC_CTRL_ADDR, 8'h71);
        chk("dac mode", 8'h01, {7'h0, dac_mode});
        chk("dac loads", 8'h01, 8'(n_load));
        run_conv(`DCC_DAC_CYC, 3'h0);
        rd_chk(`DCC_CTRL_ADDR, 8'hB1);
        ack();
        $display("test dac conversion done");

        // dropping enable mid-run must stop without a completion
        wr(`DCC_CTRL_ADDR, 8'h51);
        wr(`DCC_CTRL_ADDR, 8'h01);
        chk("abort busy", 8'h00, {7'h0, conv_busy});
        repeat (40) @(posedge clk_sys);
        #1;
        chk("abort no done", 8'h00, {7'h0, conv_done_flag});
        rd_chk(`DCC_CTRL_ADDR, 8'h01);
        $display("test abort done");

        // each timer source, the next timer's overflow ignored, retrigger while busy ignored
        for (t = 0; t < 3; t++) begin
            // input control only changes while idle; cpu and ports stay quiet
            wr(`DCC_INCTL_ADDR, 8'((t + 1) << 4));
            chk("input control", 8'((t + 1) << 4), input_control);
            wr(`DCC_CTRL_ADDR, 8'h11);
            pulse_tmr(3'h1 << ((t + 1) % 3), 1'b0);
            pulse_tmr(3'h1 << t, 1'b1);
            run_conv(`DCC_ADC_CYC, 3'h1 << t);
            rd_chk(`DCC_CTRL_ADDR, 8'h91);
            ack();
        end
        wr(`DCC_INCTL_ADDR, 8'h00);
        $display("test timer triggers done");
        wrap_up();
    end
endmodule : dcc_top_tb
`default_nettype wire
